// >>> rtl/ssipo_div.sv
`timescale 1ns/10ps
// ==========================================================================
// Restoring divider, one quotient bit per clock.
// ==========================================================================
module ssipo_div #(
	parameter int DW = 64,
	parameter int VW = 32
) (
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          start,
	input  wire logic [DW-1:0] dividend,
	input  wire logic [VW-1:0] divisor,
	output logic               done,
	output logic      [DW-1:0] quotient,
	output logic      [VW-1:0] remainder
);

	localparam int CW = $clog2(DW + 1);

	logic [CW-1:0] cnt_r;
	logic          run_r;
	logic [VW:0]   trial;
	logic          fits;

	// Trial subtraction of the divisor from the shifted partial remainder.
	always_comb
	begin
		trial = {remainder, quotient[DW-1]};
		fits  = (trial >= {1'b0, divisor});
	end

	// A start while running restarts the division; the caller never does so.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			quotient  <= '0;
			remainder <= '0;
			cnt_r     <= '0;
			run_r     <= 1'b0;
			done      <= 1'b0;
		end
		else if (start)
		begin
			quotient  <= dividend;
			remainder <= '0;
			cnt_r     <= CW'(DW);
			run_r     <= 1'b1;
			done      <= 1'b0;
		end
		else if (run_r)
		begin
			quotient  <= {quotient[DW-2:0], fits};
			remainder <= fits ? VW'(trial - {1'b0, divisor}) : trial[VW-1:0];
			cnt_r     <= cnt_r - 1'b1;
			run_r     <= (cnt_r != CW'(1));
			done      <= (cnt_r == CW'(1));
		end
		else
		begin
			done <= 1'b0;
		end
	end

endmodule : ssipo_div

// >>> rtl/ssipo_pkg.sv
// ==========================================================================
// Shared constants for the serial position output block.
// ==========================================================================
package ssipo_pkg;

	// ======================================================================
	// Register offsets, as seen on the plain register port.
	// ======================================================================
	localparam int         ADDR_W           = 7;
	localparam logic [6:0] ADDR_GEN_CONF    = 7'h00;
	localparam logic [6:0] ADDR_MONOFLOP    = 7'h04;
	localparam logic [6:0] ADDR_ENCODER_INPUT_CONFIGURATION = 7'h07;
	localparam logic [6:0] ADDR_OUT_STRUCT  = 7'h09;
	localparam logic [6:0] ADDR_EXT_POS     = 7'h50;
	localparam logic [6:0] ADDR_OUT_RES     = 7'h55;
	localparam logic [6:0] ADDR_STATUS      = 7'h60;

	// ======================================================================
	// Values after reset.
	// ======================================================================
	localparam logic [31:0] RST_GEN_CONF    = 32'h0000_6020;
	localparam logic [31:0] RST_MONOFLOP    = 32'h0000_0000;
	localparam logic [31:0] RST_ENCODER_INPUT_CONFIGURATION = 32'h0000_0000;
	localparam logic [31:0] RST_OUT_STRUCT  = 32'h0000_0000;
	localparam logic [31:0] RST_OUT_RES     = 32'h0000_0000;

	// ======================================================================
	// Field positions.
	// ======================================================================
	localparam int GEN_OUT_EN_BIT   = 24;
	localparam int GEN_DIFF_DIS_BIT = 25;
	localparam int ENC_MT_EN_BIT    = 14;
	localparam int ENC_GRAY_BIT     = 30;
	localparam int ST_LSB           = 0;
	localparam int ST_MSB           = 4;
	localparam int MT_LSB           = 5;
	localparam int MT_MSB           = 9;
	localparam int MONO_LSB         = 4;
	localparam int MONO_MSB         = 23;
	localparam int STAT_FRAME_BIT   = 0;
	localparam int STAT_VALID_BIT   = 1;
	localparam int STAT_FAULT_BIT   = 2;
	localparam int STAT_SENT_LSB    = 8;

	// ======================================================================
	// Link edge counter width and word sizes.
	// ======================================================================
	localparam int LINK_CNT_W = 4;
	localparam int WORD_W     = 64;
	localparam int LEN_W      = 7;

	// ======================================================================
	// Angle calculation sequence.
	// ======================================================================
	typedef enum logic [1:0]
	{
		SSIPO_CALC_IDLE = 2'b00,
		SSIPO_CALC_REV  = 2'b01,
		SSIPO_CALC_ANG  = 2'b10,
		SSIPO_CALC_DONE = 2'b11
	} ssipo_calc_t;

endpackage : ssipo_pkg

// >>> rtl/ssipo_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// Two-stage synchroniser; the first stage feeds only the second.
// ==========================================================================
module ssipo_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// Both stages reset to zero so the output is defined from reset on.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : ssipo_sync

// >>> rtl/ssipo_top.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
// Overview of operation
// - Write-only resolution register sets the encoder resolution for the angle.
// - Bits 4:0 of output structure give singleturn bit count minus one.
// - Bits 9:5 of output structure give multiturn bit count minus one.
// - Multiturn bits are sent only while encoder config bit 14 is set.
// - General config bit 24 enables streaming the word on the data pins.
// - Data goes out on the data pin, its inverse on the inverted data pin unless bit 25 holds that pin low.
// - The word stays frozen until the monoflop count elapses after the last edge.
// - Singleturn angle is the position scaled by the programmed resolution.
// - With multiturn on, signed revolution count precedes the singleturn bits.
// - By default the clock input is treated as a differential pair.
// - General config bit 25 makes the link single-ended, ignoring inverted pins.
// - Encoder config bit 30 converts the transmitted word to Gray code.
// - The external position in microsteps is the source of the word.
module ssipo_top (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        master_clock_pin,
	input  wire logic        master_clock_inverted_pin,
	input  wire logic [31:0] ext_position,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             serial_data_out_pin,
	output logic             serial_data_inverted_pin
);

	localparam int CW = ssipo_pkg::LINK_CNT_W;
	localparam int WW = ssipo_pkg::WORD_W;
	localparam int LW = ssipo_pkg::LEN_W;

	// ======================================================================
	// Registers.
	// ======================================================================
	logic [31:0] gen_conf_r;
	logic [31:0] monoflop_r;
	logic [31:0] encoder_input_configuration_r;
	logic [31:0] out_struct_r;
	logic [31:0] out_res_r;

	// Software writes land in the addressed register; resolution is write-only.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			gen_conf_r    <= ssipo_pkg::RST_GEN_CONF;
			monoflop_r    <= ssipo_pkg::RST_MONOFLOP;
			encoder_input_configuration_r <= ssipo_pkg::RST_ENCODER_INPUT_CONFIGURATION;
			out_struct_r  <= ssipo_pkg::RST_OUT_STRUCT;
			out_res_r     <= ssipo_pkg::RST_OUT_RES;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				ssipo_pkg::ADDR_GEN_CONF:    gen_conf_r    <= reg_wdata;
				ssipo_pkg::ADDR_MONOFLOP:    monoflop_r    <= reg_wdata;
				ssipo_pkg::ADDR_ENCODER_INPUT_CONFIGURATION: encoder_input_configuration_r <= reg_wdata;
				ssipo_pkg::ADDR_OUT_STRUCT:  out_struct_r  <= reg_wdata;
				ssipo_pkg::ADDR_OUT_RES:     out_res_r     <= reg_wdata;
				default:                     ;
			endcase
		end
	end

	// Decoded configuration fields.
	logic        out_en;
	logic        diff_dis;
	logic        mt_en;
	logic        gray_en;
	logic [5:0]  st_bits;
	logic [5:0]  mt_bits;
	logic [19:0] hold_time_count;

	assign out_en          = gen_conf_r[ssipo_pkg::GEN_OUT_EN_BIT];
	assign diff_dis        = gen_conf_r[ssipo_pkg::GEN_DIFF_DIS_BIT];
	assign mt_en           = encoder_input_configuration_r[ssipo_pkg::ENC_MT_EN_BIT];
	assign gray_en         = encoder_input_configuration_r[ssipo_pkg::ENC_GRAY_BIT];
	assign st_bits         = {1'b0, out_struct_r[ssipo_pkg::ST_MSB:ssipo_pkg::ST_LSB]} + 6'h01;
	assign mt_bits         = {1'b0, out_struct_r[ssipo_pkg::MT_MSB:ssipo_pkg::MT_LSB]} + 6'h01;
	assign hold_time_count = monoflop_r[ssipo_pkg::MONO_MSB:ssipo_pkg::MONO_LSB];

	// ======================================================================
	// Link clock domain: a gray-coded count of master clock rising edges.
	// ======================================================================
	logic [CW-1:0] link_bin_r;
	logic [CW-1:0] link_gray_r;
	logic [CW-1:0] link_bin_nxt;

	assign link_bin_nxt = link_bin_r + 1'b1;

	// The master clock may stop between frames; only a count leaves the domain.
	always_ff @(posedge master_clock_pin or negedge rstn)
	begin
		if (!rstn)
		begin
			link_bin_r  <= '0;
			link_gray_r <= '0;
		end
		else
		begin
			link_bin_r  <= link_bin_nxt;
			link_gray_r <= link_bin_nxt ^ (link_bin_nxt >> 1);
		end
	end

	// ======================================================================
	// Crossings into the system clock.
	// ======================================================================
	logic [CW-1:0] gray_s;
	logic [1:0]    pins_s;

	ssipo_sync #(
		.W (CW)
	) u_sync_cnt (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d       (link_gray_r),
		.q       (gray_s)
	);

	// Pin levels pass two flops before the fault check reads them.
	ssipo_sync #(
		.W (2)
	) u_sync_pins (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d       ({master_clock_inverted_pin, master_clock_pin}),
		.q       (pins_s)
	);

	// Gray to binary, then the number of new edges since the last cycle.
	logic [CW-1:0] edge_bin;
	logic [CW-1:0] edge_prev_r;
	logic [CW-1:0] edge_delta;
	logic          edge_seen;

	always_comb
	begin
		edge_bin[CW-1] = gray_s[CW-1];
		for (int i = CW - 2; i >= 0; i--)
		begin
			edge_bin[i] = edge_bin[i+1] ^ gray_s[i];
		end
		edge_delta = edge_bin - edge_prev_r;
		edge_seen  = out_en && (edge_delta != '0);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			edge_prev_r <= '0;
		end
		else
		begin
			edge_prev_r <= edge_bin;
		end
	end

	// In differential mode both clock pins must stay complementary.
	logic diff_fault_r;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			diff_fault_r <= 1'b0;
		end
		else
		begin
			diff_fault_r <= !diff_dis && (pins_s[0] == pins_s[1]);
		end
	end

	// ======================================================================
	// Angle and revolution calculation.
	// ======================================================================
	ssipo_pkg::ssipo_calc_t calc_state_r;
	logic [31:0] pos_r;
	logic        neg;
	logic [31:0] abs_pos;
	logic        div_start;
	logic [WW-1:0] div_dividend;
	logic        div_done;
	logic [WW-1:0] div_quo;
	logic [31:0] div_rem;
	logic [31:0] rev_r;
	logic [31:0] rem_r;
	logic [31:0] angle_r;

	assign neg     = pos_r[31];
	assign abs_pos = neg ? (32'h0000_0000 - pos_r) : pos_r;

	// First pass splits the position, second pass scales the remainder.
	always_comb
	begin
		div_start    = 1'b0;
		div_dividend = {32'h0000_0000, abs_pos};
		case (calc_state_r)
			ssipo_pkg::SSIPO_CALC_IDLE:
			begin
				div_start    = (out_res_r != 32'h0000_0000);
				div_dividend = {32'h0000_0000,
					ext_position[31] ? (32'h0000_0000 - ext_position) : ext_position};
			end
			ssipo_pkg::SSIPO_CALC_REV:
			begin
				div_start    = div_done;
				div_dividend = {32'h0000_0000, neg ? (out_res_r - div_rem) : div_rem};
				if (div_rem == 32'h0000_0000)
				begin
					div_dividend = '0;
				end
				div_dividend = div_dividend << st_bits;
			end
			default:
			begin
				div_start = 1'b0;
			end
		endcase
	end

	ssipo_div #(
		.DW (WW),
		.VW (32)
	) u_div (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.start     (div_start),
		.dividend  (div_dividend),
		.divisor   (out_res_r),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// The calculation loops freely so the word tracks the position.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			calc_state_r <= ssipo_pkg::SSIPO_CALC_IDLE;
			pos_r        <= '0;
			rev_r        <= '0;
			rem_r        <= '0;
			angle_r      <= '0;
		end
		else
		begin
			case (calc_state_r)
				ssipo_pkg::SSIPO_CALC_IDLE:
				begin
					pos_r <= ext_position;
					if (out_res_r != 32'h0000_0000)
					begin
						calc_state_r <= ssipo_pkg::SSIPO_CALC_IDLE;
					end
					if (div_start)
					begin
						calc_state_r <= ssipo_pkg::SSIPO_CALC_REV;
					end
				end
				ssipo_pkg::SSIPO_CALC_REV:
				begin
					if (div_done)
					begin
						// Floor division: negative positions round toward minus infinity.
						if (neg && (div_rem != 32'h0000_0000))
						begin
							rev_r <= 32'hFFFF_FFFF - div_quo[31:0];
						end
						else if (neg)
						begin
							rev_r <= 32'h0000_0000 - div_quo[31:0];
						end
						else
						begin
							rev_r <= div_quo[31:0];
						end
						rem_r        <= div_rem;
						calc_state_r <= ssipo_pkg::SSIPO_CALC_ANG;
					end
				end
				ssipo_pkg::SSIPO_CALC_ANG:
				begin
					if (div_done)
					begin
						angle_r      <= div_quo[31:0];
						calc_state_r <= ssipo_pkg::SSIPO_CALC_DONE;
					end
				end
				ssipo_pkg::SSIPO_CALC_DONE:
				begin
					calc_state_r <= ssipo_pkg::SSIPO_CALC_IDLE;
				end
				default:
				begin
					calc_state_r <= ssipo_pkg::SSIPO_CALC_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// Word assembly.
	// ======================================================================
	logic [WW-1:0] st_mask;
	logic [WW-1:0] mt_mask;
	logic [WW-1:0] word_plain;
	logic [WW-1:0] word_r;
	logic [LW-1:0] len_r;
	logic          word_valid_r;

	// Revolutions sit above the angle; the sign survives as the top bit.
	always_comb
	begin
		st_mask    = (64'h0000_0000_0000_0001 << st_bits) - 64'h0000_0000_0000_0001;
		mt_mask    = (64'h0000_0000_0000_0001 << mt_bits) - 64'h0000_0000_0000_0001;
		word_plain = {32'h0000_0000, angle_r} & st_mask;
		if (mt_en)
		begin
			word_plain = word_plain | (({{32{rev_r[31]}}, rev_r} & mt_mask) << st_bits);
		end
	end

	// Word is refreshed after each second pass; transmission freezes its own copy.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			word_r       <= '0;
			len_r        <= '0;
			word_valid_r <= 1'b0;
		end
		else if (out_res_r == 32'h0000_0000)
		begin
			word_valid_r <= 1'b0;
		end
		else if (calc_state_r == ssipo_pkg::SSIPO_CALC_DONE)
		begin
			word_r       <= gray_en ? (word_plain ^ (word_plain >> 1)) : word_plain;
			len_r        <= LW'(st_bits) + (mt_en ? LW'(mt_bits) : LW'(0));
			word_valid_r <= 1'b1;
		end
	end

	// ======================================================================
	// Frame control and monoflop.
	// ======================================================================
	logic          frame_r;
	logic [19:0]   hold_cnt_r;
	logic [WW-1:0] tx_word_r;
	logic [LW-1:0] tx_len_r;
	logic [LW-1:0] sent_r;
	logic [LW:0]   sent_sum;

	assign sent_sum = {1'b0, sent_r} + (LW + 1)'(edge_delta);

	// Every edge restarts the monoflop; later edges only advance the bit count, so the word is latched once per frame.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			frame_r    <= 1'b0;
			hold_cnt_r <= '0;
			tx_word_r  <= '0;
			tx_len_r   <= '0;
			sent_r     <= '0;
		end
		else if (!out_en)
		begin
			frame_r <= 1'b0;
			sent_r  <= '0;
		end
		else if (edge_seen)
		begin
			hold_cnt_r <= hold_time_count;
			frame_r    <= 1'b1;
			if (!frame_r)
			begin
				tx_word_r <= word_valid_r ? word_r : '0;
				tx_len_r  <= word_valid_r ? len_r : LW'(0);
				sent_r    <= LW'(edge_delta);
			end
			else if (sent_sum[LW])
			begin
				sent_r <= '1;
			end
			else
			begin
				sent_r <= sent_sum[LW-1:0];
			end
		end
		else if (frame_r)
		begin
			if (hold_cnt_r == 20'h00000)
			begin
				frame_r <= 1'b0;
				sent_r  <= '0;
			end
			else
			begin
				hold_cnt_r <= hold_cnt_r - 20'h00001;
			end
		end
	end

	// ======================================================================
	// Data pins.
	// ======================================================================
	logic [5:0] bit_idx;
	logic       sdo_nxt;

	assign bit_idx = 6'(tx_len_r - sent_r);

	// Idle line is high; past the last bit it stays low until the frame ends.
	always_comb
	begin
		sdo_nxt = 1'b1;
		if (frame_r && (sent_r != '0))
		begin
			sdo_nxt = (sent_r <= tx_len_r) ? tx_word_r[bit_idx] : 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			serial_data_out_pin      <= 1'b1;
			serial_data_inverted_pin <= 1'b0;
		end
		else
		begin
			serial_data_out_pin      <= sdo_nxt;
			serial_data_inverted_pin <= diff_dis ? 1'b0 : !sdo_nxt;
		end
	end

	// ======================================================================
	// Read port: data stands only in the cycle after the strobe.
	// ======================================================================
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_rdata <= '0;
		end
		else if (!reg_rd)
		begin
			reg_rdata <= '0;
		end
		else
		begin
			case (reg_addr)
				ssipo_pkg::ADDR_GEN_CONF:    reg_rdata <= gen_conf_r;
				ssipo_pkg::ADDR_MONOFLOP:    reg_rdata <= monoflop_r;
				ssipo_pkg::ADDR_ENCODER_INPUT_CONFIGURATION: reg_rdata <= encoder_input_configuration_r;
				ssipo_pkg::ADDR_OUT_STRUCT:  reg_rdata <= out_struct_r;
				ssipo_pkg::ADDR_EXT_POS:     reg_rdata <= pos_r;
				ssipo_pkg::ADDR_STATUS:
				begin
					reg_rdata <= '0;
					reg_rdata[ssipo_pkg::STAT_FRAME_BIT] <= frame_r;
					reg_rdata[ssipo_pkg::STAT_VALID_BIT] <= word_valid_r;
					reg_rdata[ssipo_pkg::STAT_FAULT_BIT] <= diff_fault_r;
					reg_rdata[ssipo_pkg::STAT_SENT_LSB +: LW] <= sent_r;
				end
				default:                     reg_rdata <= '0;
			endcase
		end
	end

endmodule : ssipo_top

// >>> testbench/ssipo_master.sv
`timescale 1ns/10ps
// ==========================================================
// SSI master: drives the transfer clock, gathers the word.
// ==========================================================
module ssipo_master (
	output logic      master_clock_pin,
	output logic      master_clock_inverted_pin,
	input  wire logic serial_data_out_pin
);
	// The clock stands high between frames.
	initial
	begin
		master_clock_pin          = 1'b1;
		master_clock_inverted_pin = 1'b0;
	end

	// A frame of n+1 rising edges; each bit is taken just before the next
	// edge, as the device answers a few cycles after an edge. With bad set the
	// inverted line sticks low, which only a single-ended link may ignore.
	task automatic read_frame(input int n, input int half, input bit bad,
		output logic [63:0] w);
		w = '0;
		for (int k = 0; k <= n; k++)
		begin
			#(half);
			master_clock_pin          = 1'b0;
			master_clock_inverted_pin = !bad;
			#(half);
			if (k > 0)
				w = {w[62:0], serial_data_out_pin};
			master_clock_pin          = 1'b1;
			master_clock_inverted_pin = 1'b0;
		end
	endtask : read_frame
endmodule : ssipo_master

// >>> testbench/ssipo_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the serial position output.
// ==========================================================
module ssipo_sva (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        master_clock_pin,
	input wire logic        master_clock_inverted_pin,
	input wire logic [31:0] ext_position,
	input wire logic [6:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        serial_data_out_pin,
	input wire logic        serial_data_inverted_pin
);
	logic        en_r;
	logic        dis_r;
	logic [20:0] mono_r;
	logic        mclk_r;
	logic [20:0] age_r;

	// Shadow of the switches, since the registers are not visible here.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			en_r  <= 1'b0;
			dis_r <= 1'b0;
		end
		else if (reg_wr && reg_addr == 7'h00)
		begin
			en_r  <= reg_wdata[24];
			dis_r <= reg_wdata[25];
		end
	end

	// Shadow of the hold count.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			mono_r <= '0;
		else if (reg_wr && reg_addr == 7'h04)
			mono_r <= {1'b0, reg_wdata[23:4]};
	end

	// Cycles since the master clock rose; it saturates so idle never wraps.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			mclk_r <= 1'b1;
			age_r  <= '1;
		end
		else
		begin
			mclk_r <= master_clock_pin;
			if (master_clock_pin && !mclk_r)
				age_r <= '0;
			else if (age_r != '1)
				age_r <= age_r + 21'd1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_zero_answer;
		##1 reg_rdata == 32'h0;
	endsequence

	// ==========================================================
	// Properties
	// ==========================================================
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside an answer");
	a_wo_read: assert property (reg_rd && reg_addr == 7'h55 |-> s_zero_answer)
		else $error("write-only register returned data");
	a_switch_read: assert property (reg_rd && reg_addr == 7'h00
		|=> reg_rdata[25:24] == {$past(dis_r), $past(en_r)})
		else $error("switch readback wrong");
	a_inv_pair: assert property (!dis_r && !$past(dis_r, 3)
		|-> serial_data_inverted_pin == !serial_data_out_pin)
		else $error("inverted data pin not the complement");
	a_single_inv: assert property (dis_r && $past(dis_r, 3)
		|-> serial_data_inverted_pin == 1'b0)
		else $error("inverted data pin active in single-ended mode");
	a_idle_high: assert property (!en_r && !$past(en_r, 8) |-> serial_data_out_pin)
		else $error("data pin left idle level while disabled");
	a_edge_lat: assert property ($fell(serial_data_out_pin)
		|-> age_r inside {[1:7]})
		else $error("data bit changed away from a master edge");
	a_hold_frozen: assert property (age_r >= 21'd8 && age_r < mono_r
		|-> $stable(serial_data_out_pin))
		else $error("data changed within the hold time");
	a_frame_end: assert property (en_r && age_r == mono_r + 21'd12
		|-> serial_data_out_pin)
		else $error("frame not ended after the hold time");
endmodule : ssipo_sva

bind ssipo_top ssipo_sva u_sva (.clk_sys(clk_sys), .rstn(rstn),
	.master_clock_pin(master_clock_pin), .ext_position(ext_position),
	.master_clock_inverted_pin(master_clock_inverted_pin), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.serial_data_out_pin(serial_data_out_pin),
	.serial_data_inverted_pin(serial_data_inverted_pin));

// >>> testbench/test_ssi_position_output.sv
`timescale 1ns/10ps
module test_ssi_position_output;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        mclk;
	logic        mclk_n;
	logic [31:0] ext_position = 32'h0;
	logic [6:0]  reg_addr = 7'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        dout;
	logic        dout_n;
	int          n_fail = 0;
	int          checks_done = 0;
	localparam int HOLD = 400;

	ssipo_top uut (.clk_sys(clk_sys), .rstn(rstn), .master_clock_pin(mclk),
		.master_clock_inverted_pin(mclk_n), .ext_position(ext_position),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_data_out_pin(dout),
		.serial_data_inverted_pin(dout_n));
	ssipo_master u_mst (.master_clock_pin(mclk), .master_clock_inverted_pin(mclk_n),
		.serial_data_out_pin(dout));

	// System clock, 5 ns.
	always #2.5 clk_sys = !clk_sys;

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Writes leave the strobe up so a read may follow at once.
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [31:0] e, input string nm);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wr   <= 1'b0;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(nm, {32'h0, e}, {32'h0, reg_rdata});
	endtask : rd

	// Word from floor revolutions and scaled remainder, mt bits of signed turns.
	function automatic logic [63:0] exp_word(input longint p, input longint r,
		input int st, input int mt, input bit gray);
		longint      rev;
		logic [63:0] w;
		rev = p / r;
		if (rev * r > p)
			rev = rev - 1;
		w = (64'(rev) & ((64'h1 << mt) - 64'h1)) << st;
		w = w | 64'(((p - rev * r) << st) / r);
		if (gray)
			w = w ^ (w >> 1);
		return w;
	endfunction : exp_word

	task automatic t_regs();
		rd(7'h00, ssipo_pkg::RST_GEN_CONF, "gen reset");
		wr(7'h09, 32'h0000_0086);
		rd(7'h09, 32'h0000_0086, "structure");
		wr(7'h55, 32'h0000_1234);
		rd(7'h55, 32'h0, "resolution");
		rd(7'h33, 32'h0, "unmapped");
	endtask : t_regs

	// Programs one layout, lets the word refresh, reads a frame, then times
	// the return to idle; the count starts late as the last bit lags the edge.
	task automatic t_case(input int st, input int mt, input bit me, input bit gray,
		input bit se, input longint p, input longint r, input int half);
		logic [63:0] w;
		int          cnt;
		wr(7'h55, 32'(r));
		wr(7'h09, 32'(((mt - 1) << 5) | (st - 1)));
		wr(7'h07, {1'b0, gray, 15'h0, me, 14'h0});
		wr(7'h04, 32'(HOLD << 4));
		wr(7'h00, ssipo_pkg::RST_GEN_CONF | {6'h0, se, 1'b1, 24'h0});
		@(posedge clk_sys);
		reg_wr       <= 1'b0;
		ext_position <= 32'(p);
		repeat (300) @(posedge clk_sys);
		#2.3;
		u_mst.read_frame(st + (me ? mt : 0), half, se, w);
		chk("frame", exp_word(p, r, st, me ? mt : 0, gray), w);
		repeat (8) @(posedge clk_sys);
		#1;
		for (cnt = 8; dout !== 1'b1 && cnt < 2000; cnt++)
		begin
			@(posedge clk_sys);
			#1;
		end
		chk("hold", 64'h1, 64'(cnt >= HOLD && cnt <= HOLD + 12));
		rd(7'h50, 32'(p), "position");
		rd(7'h60, 32'h0000_0002, "status");
	endtask : t_case

	task automatic t_off();
		logic [63:0] w;
		wr(7'h00, ssipo_pkg::RST_GEN_CONF);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (20) @(posedge clk_sys);
		#2.3;
		u_mst.read_frame(8, 15, 1'b0, w);
		chk("disabled", 64'hFF, w);
	endtask : t_off

	task automatic give_verdict();
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// Main sequence.
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		t_regs();
		t_case(7, 5, 1, 0, 0, 12345, 1000, 15);
		t_case(7, 5, 1, 0, 0, -2500, 1000, 15);
		t_case(7, 5, 0, 0, 0, 12345, 1000, 15);
		t_case(7, 5, 1, 1, 0, -2500, 1000, 15);
		t_case(1, 1, 1, 0, 1, 777, 100, 15);
		t_case(16, 32, 1, 0, 0, -123456789, 4096, 15);
		t_off();
		give_verdict();
	end

	// Watchdog, well past the few tens of microseconds the run needs.
	initial
	begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule : test_ssi_position_output
